// >>> rtl/acc_stack_load_unit.sv
// accumulator, eight-level stack, load and output sequencing
`timescale 1ns/1ps
//
// Contract
// RL1: 32-bit accumulator, 16-bit words, pairs for doubles
// RL2: manipulation leaves only its result
// RL3: double manipulation operand spans two words
// RL4: later loads push old accumulator first
// RL5: output cancels the pending push
// RL6: push shifts all levels down one
// RL7: eight stack levels of 32 bits
// RL8: eighth level lost on overflow push
// RL9: pop takes top, shifts stack up
// RL10: pointer word is the operand's address
// RL11: load address converts octal to binary
// RL12: word load zeroes upper half
// RL13: double load fills whole accumulator
// RL14: every load updates load-zero flag
// RL15: bit-field load gathers bits from bit zero
// RL16: bits above count cleared
// RL17: accumulator cleared at end of scan
// RL18: word output writes low half
// RL19: pop updates result-zero flag
// RL20: stack resets to zero, empty pop gives zero
module acc_stack_load_unit
  import acc_stack_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic op_valid,
  output logic op_ready,
  input wire acc_stack_pkg::op_t op_code,
  input wire acc_stack_pkg::src_t op_src,
  input wire logic [acc_stack_pkg::WORD_W-1:0] op_addr,
  input wire logic [acc_stack_pkg::ACC_W-1:0] op_const,
  input wire logic [acc_stack_pkg::CNT_W-1:0] op_bits,
  input wire logic end_of_scan,
  output logic op_done,
  output logic mem_rd_en,
  output logic [acc_stack_pkg::WORD_W-1:0] mem_rd_addr,
  input wire logic [acc_stack_pkg::WORD_W-1:0] mem_rd_data,
  output logic mem_wr_en,
  output logic [acc_stack_pkg::WORD_W-1:0] mem_wr_addr,
  output logic [acc_stack_pkg::WORD_W-1:0] mem_wr_data,
  output logic bit_rd_en,
  output logic [acc_stack_pkg::WORD_W-1:0] bit_rd_addr,
  input wire logic bit_rd_data,
  output logic alu_req,
  output logic [acc_stack_pkg::ACC_W-1:0] alu_a,
  output logic [acc_stack_pkg::ACC_W-1:0] alu_b,
  input wire logic [acc_stack_pkg::ACC_W-1:0] alu_result,
  output logic [acc_stack_pkg::ACC_W-1:0] acc,
  output logic [acc_stack_pkg::ACC_W-1:0] stack_top,
  output logic load_zero_flag,
  output logic result_zero_flag
);
  import acc_stack_pkg::*;

  state_t state, next_state;
  op_t op, next_op;
  logic [WORD_W-1:0] addr, next_addr;
  logic [ACC_W-1:0] operand, next_operand;
  logic [CNT_W-1:0] bit_cnt, next_bit_cnt;
  logic [CNT_W-1:0] bit_idx, next_bit_idx;
  logic [ACC_W-1:0] next_acc;
  logic loaded, next_loaded;
  logic next_load_zero_flag, next_result_zero_flag;
  logic next_op_done;
  logic next_mem_rd_en, next_mem_wr_en, next_bit_rd_en;
  logic [WORD_W-1:0] next_mem_rd_addr, next_mem_wr_addr, next_mem_wr_data, next_bit_rd_addr;
  logic [ACC_W-1:0] stack_q [STACK_DEPTH];
  logic [OCT_W-1:0] oct_bin;
  logic [ACC_W-1:0] load_value;
  logic is_load, is_double, push, pop;

  // level 0 is the top; the bottom refills with zero so an empty pop yields zero
  for (genvar i = 0; i < STACK_DEPTH; i++)
  begin : g_level
    stack_level u_level (
      .ref_clk(ref_clk),
      .rst(rst),
      .push(push),
      .pop(pop),
      .from_above((i == 0) ? acc : stack_q[(i == 0) ? 0 : i - 1]), // [RL6] [RL7]
      .from_below((i == STACK_DEPTH - 1) ? STACK_RESET : stack_q[(i == STACK_DEPTH - 1) ? i : i + 1]), // [RL8] [RL20]
      .value(stack_q[i])
    );
  end

  octal_to_bin u_oct (
    .digits(operand),
    .value(oct_bin)
  );

  assign stack_top = stack_q[0];
  assign op_ready = (state == st_idle) && !end_of_scan;
  assign alu_req = (state == st_exec) && ((op == manip_word_op) || (op == manip_double_op));
  assign alu_a = acc;
  assign alu_b = operand; // [RL3]
  assign is_load = (op == load_word_op) || (op == load_double_op) || (op == load_address_op)
                   || (op == load_bitfield_op);
  assign is_double = (op == load_double_op) || (op == manip_double_op);
  assign push = (state == st_exec) && is_load && loaded; // [RL4] [RL5]
  assign pop = (state == st_exec) && (op == pop_op); // [RL9]
  assign load_value = (op == load_address_op) ? {{(ACC_W - OCT_W){1'b0}}, oct_bin} : operand; // [RL11]

  always_comb
  begin
    next_state = state;
    next_op = op;
    next_addr = addr;
    next_operand = operand;
    next_bit_cnt = bit_cnt;
    next_bit_idx = bit_idx;
    next_acc = acc;
    next_loaded = loaded;
    next_load_zero_flag = load_zero_flag;
    next_result_zero_flag = result_zero_flag;
    next_op_done = 1'b0;
    next_mem_rd_en = 1'b0;
    next_mem_rd_addr = mem_rd_addr;
    next_mem_wr_en = 1'b0;
    next_mem_wr_addr = mem_wr_addr;
    next_mem_wr_data = mem_wr_data;
    next_bit_rd_en = 1'b0;
    next_bit_rd_addr = bit_rd_addr;
    case (state)
      st_idle:
      begin
        if (end_of_scan)
        begin
          next_acc = ACC_RESET; // [RL17]
          next_loaded = 1'b0;
        end
        else if (op_valid)
        begin
          next_op = op_code;
          next_addr = op_addr;
          next_operand = ACC_RESET;
          next_bit_idx = CNT_ZERO;
          if (op_bits == CNT_ZERO)
          begin
            next_bit_cnt = BITS_MIN;
          end
          else if (op_bits > BITS_MAX)
          begin
            next_bit_cnt = BITS_MAX;
          end
          else
          begin
            next_bit_cnt = op_bits;
          end
          if (op_code == load_bitfield_op)
          begin
            next_bit_rd_en = 1'b1; // [RL15]
            next_bit_rd_addr = op_addr;
            next_state = st_bits;
          end
          else if ((op_code == pop_op) || (op_code == load_address_op) || (op_code == op_nop))
          begin
            next_operand = op_const;
            next_state = st_exec;
          end
          else if (op_src == src_ptr)
          begin
            next_mem_rd_en = 1'b1;
            next_mem_rd_addr = op_addr;
            next_state = st_ptr;
          end
          else if ((op_code == store_word_op) || (op_code == store_double_op))
          begin
            next_state = st_exec;
          end
          else if (op_src == src_const)
          begin
            if ((op_code == load_double_op) || (op_code == manip_double_op))
            begin
              next_operand = op_const; // [RL13]
            end
            else
            begin
              next_operand = {WORD_ZERO, op_const[WORD_W-1:0]}; // [RL12]
            end
            next_state = st_exec;
          end
          else
          begin
            next_mem_rd_en = 1'b1;
            next_mem_rd_addr = op_addr;
            next_state = st_lo;
          end
        end
      end
      st_ptr:
      begin
        if (!mem_rd_en)
        begin
          next_addr = mem_rd_data; // [RL10]
          if ((op == store_word_op) || (op == store_double_op))
          begin
            next_state = st_exec;
          end
          else
          begin
            next_mem_rd_en = 1'b1;
            next_mem_rd_addr = mem_rd_data;
            next_state = st_lo;
          end
        end
      end
      st_lo:
      begin
        if (!mem_rd_en)
        begin
          next_operand = {WORD_ZERO, mem_rd_data}; // [RL12]
          if (is_double)
          begin
            next_mem_rd_en = 1'b1;
            next_mem_rd_addr = addr + WORD_STEP; // [RL1]
            next_state = st_hi;
          end
          else
          begin
            next_state = st_exec;
          end
        end
      end
      st_hi:
      begin
        if (!mem_rd_en)
        begin
          next_operand = {mem_rd_data, operand[WORD_W-1:0]}; // [RL13]
          next_state = st_exec;
        end
      end
      st_bits:
      begin
        if (!bit_rd_en)
        begin
          next_operand[bit_idx[4:0]] = bit_rd_data; // [RL15] [RL16]
          if (bit_idx == bit_cnt - CNT_STEP)
          begin
            next_state = st_exec;
          end
          else
          begin
            next_bit_idx = bit_idx + CNT_STEP;
            next_bit_rd_en = 1'b1;
            next_bit_rd_addr = addr + {{(WORD_W - CNT_W){1'b0}}, bit_idx + CNT_STEP};
          end
        end
      end
      st_exec:
      begin
        next_state = st_idle;
        next_op_done = 1'b1;
        if (is_load)
        begin
          next_acc = load_value; // [RL4]
          next_loaded = 1'b1;
          next_load_zero_flag = (load_value == ACC_RESET); // [RL14]
        end
        else if (alu_req)
        begin
          next_acc = alu_result; // [RL2]
          next_result_zero_flag = (alu_result == ACC_RESET);
        end
        else if (op == pop_op)
        begin
          next_acc = stack_q[0]; // [RL9]
          next_result_zero_flag = (stack_q[0] == ACC_RESET); // [RL19]
        end
        else if ((op == store_word_op) || (op == store_double_op))
        begin
          next_loaded = 1'b0; // [RL5]
          next_mem_wr_en = 1'b1;
          next_mem_wr_addr = addr;
          next_mem_wr_data = acc[WORD_W-1:0]; // [RL18]
          if (op == store_double_op)
          begin
            next_op_done = 1'b0;
            next_state = st_wr_hi;
          end
        end
      end
      st_wr_hi:
      begin
        next_mem_wr_en = 1'b1;
        next_mem_wr_addr = addr + WORD_STEP; // [RL1]
        next_mem_wr_data = acc[ACC_W-1:WORD_W];
        next_op_done = 1'b1;
        next_state = st_idle;
      end
      default:
      begin
        next_state = st_idle;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state <= st_idle;
      op <= op_nop;
      addr <= WORD_ZERO;
      operand <= ACC_RESET;
      bit_cnt <= BITS_MIN;
      bit_idx <= CNT_ZERO;
      acc <= ACC_RESET;
      loaded <= 1'b0;
      load_zero_flag <= 1'b0;
      result_zero_flag <= 1'b0;
      op_done <= 1'b0;
      mem_rd_en <= 1'b0;
      mem_rd_addr <= WORD_ZERO;
      mem_wr_en <= 1'b0;
      mem_wr_addr <= WORD_ZERO;
      mem_wr_data <= WORD_ZERO;
      bit_rd_en <= 1'b0;
      bit_rd_addr <= WORD_ZERO;
    end
    else
    begin
      state <= next_state;
      op <= next_op;
      addr <= next_addr;
      operand <= next_operand;
      bit_cnt <= next_bit_cnt;
      bit_idx <= next_bit_idx;
      acc <= next_acc;
      loaded <= next_loaded;
      load_zero_flag <= next_load_zero_flag;
      result_zero_flag <= next_result_zero_flag;
      op_done <= next_op_done;
      mem_rd_en <= next_mem_rd_en;
      mem_rd_addr <= next_mem_rd_addr;
      mem_wr_en <= next_mem_wr_en;
      mem_wr_addr <= next_mem_wr_addr;
      mem_wr_data <= next_mem_wr_data;
      bit_rd_en <= next_bit_rd_en;
      bit_rd_addr <= next_bit_rd_addr;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  property p_push_shift;
    push |=> (stack_q[0] == $past(acc)) && (stack_q[1] == $past(stack_q[0]));
  endproperty
  a_push_shift: assert property (p_push_shift) else $error("push did not shift the stack"); // [RL6]
  property p_overflow;
    push |=> stack_q[7] == $past(stack_q[6]);
  endproperty
  a_overflow: assert property (p_overflow) else $error("eighth level not replaced on push"); // [RL8]
  property p_pop;
    pop |=> (acc == $past(stack_q[0])) && (stack_q[0] == $past(stack_q[1])) && (stack_q[7] == ACC_RESET);
  endproperty
  a_pop: assert property (p_pop) else $error("pop did not move the stack up"); // [RL9]
  // checker helper kept apart from the pending-push flag, so a broken flag still trips the check below
  logic after_out, next_after_out;

  always_comb
  begin
    next_after_out = after_out;
    if ((state == st_exec) && is_load)
    begin
      next_after_out = 1'b0;
    end
    else if ((state == st_exec) && ((op == store_word_op) || (op == store_double_op)))
    begin
      next_after_out = 1'b1;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      after_out <= 1'b0;
    end
    else
    begin
      after_out <= next_after_out;
    end
  end

  property p_no_push_after_out;
    (state == st_exec) && is_load && after_out |-> !push;
  endproperty
  a_no_push_after_out: assert property (p_no_push_after_out) else $error("load after output pushed"); // [RL5]
  property p_out_clears;
    (state == st_exec) && ((op == store_word_op) || (op == store_double_op)) |=> !loaded;
  endproperty
  a_out_clears: assert property (p_out_clears) else $error("output did not cancel the push"); // [RL5]
  property p_first_load;
    (state == st_exec) && is_load && !loaded |-> !push ##1 loaded;
  endproperty
  a_first_load: assert property (p_first_load) else $error("first load pushed"); // [RL4]
  property p_word_upper;
    (state == st_exec) && (op == load_word_op) |=> acc[31:16] == WORD_ZERO;
  endproperty
  a_word_upper: assert property (p_word_upper) else $error("upper half not zero on word load"); // [RL12]
  property p_load_zero;
    (state == st_exec) && is_load |=> load_zero_flag == (acc == ACC_RESET);
  endproperty
  a_load_zero: assert property (p_load_zero) else $error("load zero flag wrong"); // [RL14]
  property p_scan_clear;
    (state == st_idle) && end_of_scan |=> (acc == ACC_RESET) && !loaded;
  endproperty
  a_scan_clear: assert property (p_scan_clear) else $error("accumulator not cleared at scan end"); // [RL17]
  property p_store_word;
    (state == st_exec) && (op == store_word_op) |=> mem_wr_en && (mem_wr_data == $past(acc[15:0]));
  endproperty
  a_store_word: assert property (p_store_word) else $error("word output wrong"); // [RL18]
  property p_bits_clear;
    (state == st_exec) && (op == load_bitfield_op) |=> (acc >> bit_cnt) == ACC_RESET;
  endproperty
  a_bits_clear: assert property (p_bits_clear) else $error("bits above count not cleared"); // [RL16]
  property p_manip;
    alu_req |=> acc == $past(alu_result);
  endproperty
  a_manip: assert property (p_manip) else $error("manipulation result not held"); // [RL2]
  property p_pop_flag;
    pop |=> result_zero_flag == (acc == ACC_RESET);
  endproperty
  a_pop_flag: assert property (p_pop_flag) else $error("pop zero flag wrong"); // [RL19]

  c_overflow: cover property (push && (stack_q[7] != ACC_RESET));
  c_pop: cover property (pop && (stack_q[0] != ACC_RESET));
  c_store_double: cover property ((state == st_wr_hi) ##1 op_done);
  c_bitfield: cover property ((state == st_exec) && (op == load_bitfield_op) && (bit_cnt == BITS_MAX));
endmodule

// >>> rtl/acc_stack_pkg.sv
// shared widths, encodings and reset values for the accumulator and stack load unit
package acc_stack_pkg;
  localparam int ACC_W = 32;
  localparam int WORD_W = 16;
  localparam int STACK_DEPTH = 8;
  localparam int CNT_W = 6;
  localparam int OCT_DIGITS = 8;
  localparam int OCT_W = 3 * OCT_DIGITS;
  localparam logic [ACC_W-1:0] ACC_RESET = 32'h0000_0000;
  localparam logic [ACC_W-1:0] STACK_RESET = 32'h0000_0000;
  localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
  localparam logic [WORD_W-1:0] WORD_STEP = 16'h0001;
  localparam logic [CNT_W-1:0] BITS_MIN = 6'h01;
  localparam logic [CNT_W-1:0] BITS_MAX = 6'h20;
  localparam logic [CNT_W-1:0] CNT_ZERO = 6'h00;
  localparam logic [CNT_W-1:0] CNT_STEP = 6'h01;

  typedef enum logic [3:0] {
    op_nop = 4'h0,
    load_word_op = 4'h1,
    load_double_op = 4'h2,
    load_address_op = 4'h3,
    load_bitfield_op = 4'h4,
    store_word_op = 4'h5,
    store_double_op = 4'h6,
    pop_op = 4'h7,
    manip_word_op = 4'h8,
    manip_double_op = 4'h9
  } op_t;

  typedef enum logic [1:0] {
    src_const = 2'h0,
    src_mem = 2'h1,
    src_ptr = 2'h2
  } src_t;

  typedef enum logic [2:0] {
    st_idle = 3'h0,
    st_ptr = 3'h1,
    st_lo = 3'h2,
    st_hi = 3'h3,
    st_bits = 3'h4,
    st_exec = 3'h5,
    st_wr_hi = 3'h6
  } state_t;
endpackage

// >>> rtl/octal_to_bin.sv
// converts nibble-coded octal digits into a binary value
`timescale 1ns/1ps
module octal_to_bin
  import acc_stack_pkg::*;
(
  input wire logic [4*acc_stack_pkg::OCT_DIGITS-1:0] digits,
  output logic [acc_stack_pkg::OCT_W-1:0] value
);
  // bit 3 of every nibble is ignored: an octal digit never exceeds 7
  for (genvar i = 0; i < OCT_DIGITS; i++)
  begin : g_digit
    assign value[3*i +: 3] = digits[4*i +: 3];
  end
endmodule

// >>> rtl/stack_level.sv
// one level of the push-down accumulator stack
`timescale 1ns/1ps
module stack_level
  import acc_stack_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic push,
  input wire logic pop,
  input wire logic [acc_stack_pkg::ACC_W-1:0] from_above,
  input wire logic [acc_stack_pkg::ACC_W-1:0] from_below,
  output logic [acc_stack_pkg::ACC_W-1:0] value
);
  logic [ACC_W-1:0] next_value;

  always_comb
  begin
    next_value = value;
    if (push)
    begin
      next_value = from_above;
    end
    else if (pop)
    begin
      next_value = from_below;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      value <= STACK_RESET;
    end
    else
    begin
      value <= next_value;
    end
  end
endmodule

// >>> verif/mem_model.sv
// word memory, discrete bit memory and combinational alu facing the load unit
`timescale 1ns/1ps
module mem_model
  import acc_stack_pkg::*;
(
  input wire logic ref_clk,
  input wire logic mem_rd_en,
  input wire logic [acc_stack_pkg::WORD_W-1:0] mem_rd_addr,
  output logic [acc_stack_pkg::WORD_W-1:0] mem_rd_data,
  input wire logic mem_wr_en,
  input wire logic [acc_stack_pkg::WORD_W-1:0] mem_wr_addr,
  input wire logic [acc_stack_pkg::WORD_W-1:0] mem_wr_data,
  input wire logic bit_rd_en,
  input wire logic [acc_stack_pkg::WORD_W-1:0] bit_rd_addr,
  output logic bit_rd_data,
  input wire logic alu_req,
  input wire logic [acc_stack_pkg::ACC_W-1:0] alu_a,
  input wire logic [acc_stack_pkg::ACC_W-1:0] alu_b,
  output logic [acc_stack_pkg::ACC_W-1:0] alu_result
);
  logic [15:0] mem [0:255];
  logic [63:0] bits;
  initial
  begin
    mem_rd_data = 16'h0000;
    bit_rd_data = 1'b0;
    bits = 64'h0;
    for (int i = 0; i < 256; i++)
      mem[i] = 16'h0000;
  end
  // read data is valid one cycle after the strobe only; otherwise it toggles so stale reads show
  always @(posedge ref_clk)
  begin
    if (mem_rd_en)
      mem_rd_data <= mem[mem_rd_addr[7:0]];
    else
      mem_rd_data <= ~mem_rd_data;
    if (bit_rd_en)
      bit_rd_data <= bits[bit_rd_addr[5:0]];
    else
      bit_rd_data <= ~bit_rd_data;
    if (mem_wr_en)
      mem[mem_wr_addr[7:0]] <= mem_wr_data;
  end
  // result is garbage outside a request
  assign alu_result = alu_req ? (alu_a ^ alu_b) : ~alu_a;
endmodule

// >>> verif/tb_acc_stack_load_unit.sv
// self-checking testbench for the accumulator and stack load unit
`timescale 1ns/1ps
module tb_acc_stack_load_unit;
  import acc_stack_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic op_valid = 1'b0;
  logic op_ready;
  op_t op_code = op_nop;
  src_t op_src = src_const;
  logic [15:0] op_addr = 16'h0000;
  logic [31:0] op_const = 32'h0000_0000;
  logic [5:0] op_bits = 6'h01;
  logic end_of_scan = 1'b0;
  logic op_done, mem_rd_en, mem_wr_en, bit_rd_en, bit_rd_data, alu_req, load_zero_flag, result_zero_flag;
  logic [15:0] mem_rd_addr, mem_rd_data, mem_wr_addr, mem_wr_data, bit_rd_addr;
  logic [31:0] alu_a, alu_b, alu_result, acc, stack_top;
  int err_total = 0;
  int total_checks = 0;

  acc_stack_load_unit acc_stack_load_unit_inst (.ref_clk(ref_clk), .rst(rst), .op_valid(op_valid),
    .op_ready(op_ready), .op_code(op_code), .op_src(op_src), .op_addr(op_addr), .op_const(op_const),
    .op_bits(op_bits), .end_of_scan(end_of_scan), .op_done(op_done), .mem_rd_en(mem_rd_en),
    .mem_rd_addr(mem_rd_addr), .mem_rd_data(mem_rd_data), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .bit_rd_en(bit_rd_en), .bit_rd_addr(bit_rd_addr), .bit_rd_data(bit_rd_data),
    .alu_req(alu_req), .alu_a(alu_a), .alu_b(alu_b), .alu_result(alu_result), .acc(acc),
    .stack_top(stack_top), .load_zero_flag(load_zero_flag), .result_zero_flag(result_zero_flag));

  mem_model mem_model_inst (.ref_clk(ref_clk), .mem_rd_en(mem_rd_en), .mem_rd_addr(mem_rd_addr),
    .mem_rd_data(mem_rd_data), .mem_wr_en(mem_wr_en), .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data),
    .bit_rd_en(bit_rd_en), .bit_rd_addr(bit_rd_addr), .bit_rd_data(bit_rd_data), .alu_req(alu_req),
    .alu_a(alu_a), .alu_b(alu_b), .alu_result(alu_result));

  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // request held until the edge that takes it; returns in the cycle op_done is high
  task automatic run_op(input op_t c, input src_t s, input logic [15:0] a, input logic [31:0] k,
    input logic [5:0] n);
    int i;
    @(posedge ref_clk);
    op_valid <= 1'b1;
    op_code <= c;
    op_src <= s;
    op_addr <= a;
    op_const <= k;
    op_bits <= n;
    @(negedge ref_clk);
    for (i = 0; i < 50 && op_ready !== 1'b1; i++)
      @(negedge ref_clk);
    @(posedge ref_clk);
    op_valid <= 1'b0;
    for (i = 0; i < 200 && op_done !== 1'b1; i++)
      @(negedge ref_clk);
    check({31'h0, op_done}, 32'h1);
  endtask

  task automatic scan_end();
    @(posedge ref_clk);
    end_of_scan <= 1'b1;
    repeat (2) @(posedge ref_clk);
    end_of_scan <= 1'b0;
    @(negedge ref_clk);
  endtask

  task automatic t_reset_pop();
    check(stack_top, 32'h0);
    run_op(pop_op, src_const, 16'h0, 32'h0, 6'h01);
    check(acc, 32'h0);
    check({31'h0, result_zero_flag}, 32'h1);
    $display("test reset_pop done");
  endtask

  task automatic t_loads();
    mem_model_inst.mem[8'h20] = 16'h0040;
    mem_model_inst.mem[8'h40] = 16'hBEEF;
    mem_model_inst.mem[8'h50] = 16'h5678;
    mem_model_inst.mem[8'h51] = 16'h1234;
    mem_model_inst.bits = 64'h0000_0000_0000_0A50;
    scan_end();
    run_op(load_word_op, src_const, 16'h0, 32'hABCD_1234, 6'h01);
    check(acc, 32'h0000_1234);
    check(stack_top, 32'h0);
    check({31'h0, load_zero_flag}, 32'h0);
    run_op(load_word_op, src_ptr, 16'h0020, 32'h0, 6'h01);
    check(acc, 32'h0000_BEEF);
    check(stack_top, 32'h0000_1234);
    run_op(load_double_op, src_mem, 16'h0050, 32'h0, 6'h01);
    check(acc, 32'h1234_5678);
    check(stack_top, 32'h0000_BEEF);
    run_op(load_address_op, src_const, 16'h0, 32'h0004_0400, 6'h01);
    check(acc, 32'h0000_4100);
    run_op(load_bitfield_op, src_const, 16'h0004, 32'h0, 6'h07);
    check(acc, 32'h0000_0025);
    run_op(load_bitfield_op, src_const, 16'h0000, 32'h0, 6'h20);
    check(acc, 32'h0000_0A50);
    run_op(load_double_op, src_const, 16'h0, 32'h0000_0000, 6'h01);
    check({31'h0, load_zero_flag}, 32'h1);
    check(stack_top, 32'h0000_0A50);
    $display("test loads done");
  endtask

  task automatic t_store();
    run_op(load_double_op, src_const, 16'h0, 32'hCAFE_F00D, 6'h01);
    run_op(store_word_op, src_mem, 16'h0060, 32'h0, 6'h01);
    // the write strobe stands in the done cycle, so the word lands at the following edge
    @(negedge ref_clk);
    check({16'h0, mem_model_inst.mem[8'h60]}, 32'h0000_F00D);
    run_op(store_double_op, src_mem, 16'h0062, 32'h0, 6'h01);
    check({16'h0, mem_wr_addr}, 32'h0000_0063);
    @(negedge ref_clk);
    check({mem_model_inst.mem[8'h63], mem_model_inst.mem[8'h62]}, 32'hCAFE_F00D);
    run_op(load_word_op, src_const, 16'h0, 32'h0000_0777, 6'h01);
    check(stack_top, 32'h0000_0000);
    check(acc, 32'h0000_0777);
    run_op(store_word_op, src_ptr, 16'h0020, 32'h0, 6'h01);
    @(negedge ref_clk);
    check({16'h0, mem_model_inst.mem[8'h40]}, 32'h0000_0777);
    $display("test store done");
  endtask

  task automatic t_manip();
    run_op(manip_double_op, src_const, 16'h0, 32'h1111_0000, 6'h01);
    check(acc, 32'h1111_0777);
    check({31'h0, result_zero_flag}, 32'h0);
    check(stack_top, 32'h0);
    run_op(manip_double_op, src_const, 16'h0, 32'h1111_0777, 6'h01);
    check({31'h0, result_zero_flag}, 32'h1);
    run_op(manip_word_op, src_const, 16'h0, 32'hABCD_00FF, 6'h01);
    check(acc, 32'h0000_00FF);
    $display("test manip done");
  endtask

  task automatic t_stack();
    scan_end();
    check(acc, 32'h0);
    for (int k = 1; k <= 10; k++)
    begin
      run_op(load_double_op, src_const, 16'h0, 32'(k), 6'h01);
      check(stack_top, (k == 1) ? 32'h0 : 32'(k - 1));
    end
    for (int k = 9; k >= 2; k--)
    begin
      run_op(pop_op, src_const, 16'h0, 32'h0, 6'h01);
      check(acc, 32'(k));
    end
    run_op(pop_op, src_const, 16'h0, 32'h0, 6'h01);
    check(acc, 32'h0);
    check({31'h0, result_zero_flag}, 32'h1);
    $display("test stack done");
  endtask

  initial
  begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    @(negedge ref_clk);
    t_reset_pop();
    t_loads();
    t_store();
    t_manip();
    t_stack();
    end_sim();
  end

  initial
  begin
    #100000;
    err_total++;
    end_sim();
  end
endmodule
